/* host_model.sv */
/*
  Host model that sends one command word per frame on the serial pins.
  Assumes clk keeps running; sclk stands low between frames except while noise() pulses it.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output var serial_cmd_pkg::serial_in_t serial_in,
  input wire logic serial_out
);
  import serial_cmd_pkg::*;
  initial serial_in = 3'b001;
  // sixteen clocks a word, twenty-four with lead prefix, MSB first
  task automatic xfer(input logic [15:0] w, input logic [7:0] pre, input bit lead,
    output logic [15:0] got);
    logic [23:0] s;
    int n;
    s = {pre, w};
    n = lead ? 24 : 16;
    got = '0;
    @(posedge clk) #2;
    serial_in.cs_n = 1'b0;
    serial_in.din = s[n-1];
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in.sclk = 1'b1;
      #60 serial_in.sclk = 1'b0;
      // Released line flips so stale data cannot match
      serial_in.din = (i > 0) ? s[i-1] : ~s[0];
      #100 got = {got[14:0], serial_out};
    end
    serial_in.cs_n = 1'b1;
    #100;
  endtask : xfer
  task automatic noise();
    repeat (16) begin
      serial_in.sclk = 1'b1;
      serial_in.din = ~serial_in.din;
      #60 serial_in.sclk = 1'b0;
      #100;
    end
  endtask : noise
endmodule : host_model
`default_nettype wire

/* pin_sync.sv */
/*
  Two-stage synchroniser for a bundle of asynchronous levels.
  Assumes inputs are free of glitches shorter than two clock periods.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* serial_cmd_pkg.sv */
/*
  Shared constants and types for the serial command port with change detect.
  Assumes a single 50 MHz system clock; serial pins are asynchronous to it.
*/
package serial_cmd_pkg;
  localparam int WORD_W = 16;
  localparam int WATCH_W = 7;
  localparam int SYNC_STAGES = 2;
  localparam int READ_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam logic [6:0] ADDR_NULL = 7'h00;
  localparam logic [6:0] ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ADDR_MASK = 7'h06;
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_DETECT_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  typedef struct packed {
    logic sclk;
    logic din;
    logic cs_n;
  } serial_in_t;

  typedef struct packed {
    logic is_read;
    logic [6:0] addr;
    logic [7:0] data;
  } command_t;
endpackage : serial_cmd_pkg

/* serial_cmd_port_change_detect.sv */
/*
  Serial command front end with transition detection for seven watched pins.
  Assumes the serial clock is much slower than clk (160 ns period vs 20 ns)
  and that sys_rst stands for power-up reset.
*/
// Summary of operation
// - Input bit reappears at output 15.5 clocks later
// - Shift data in on serial clock rise
// - Chip select high leaves shift register unchanged except for read load
// - Chip select rise latches and executes word
// - Only last sixteen bits are kept
// - Read: bit 15 set, address in 14..8
// - Read loads register data into low byte
// - Power-up resets registers, enters shutdown
// - Any watched change gives one alert
// - Mask selects watched pins, any direction
// - Config write with enable reloads snapshot
// - Enable write arms and lowers alert
// - Armed mismatch latches alert high
// - Alert cleared only by mask access or enable write
// - Latching alert disarms until next enable
// - Word: address upper byte, data lower
// - Ignore serial activity outside chip select
// - Serial output always actively driven
`timescale 1ns/100ps
`default_nettype none
module serial_cmd_port_change_detect
  import serial_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins
  input wire serial_cmd_pkg::serial_in_t serial_in,
  output logic serial_out,
  // Watched pins and alert
  input wire logic [serial_cmd_pkg::WATCH_W-1:0] watched_pins,
  output logic alert_pin,
  // Status
  output logic shutdown,
  output logic detect_armed,
  output logic [7:0] config_value,
  output logic [serial_cmd_pkg::WATCH_W-1:0] watch_mask
);
  import serial_cmd_pkg::*;

  logic [2:0] link_sync;
  logic [WATCH_W-1:0] pins_sync;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [7:0] config_reg;
  logic [WATCH_W-1:0] mask_reg;
  logic [WATCH_W-1:0] snap_reg;
  logic armed_reg;
  logic alert_reg;

  // pins synchronised
  // Select enters inverted: a cleared synchroniser must read as idle,
  // else release of reset fakes a select rise and runs a stale word
  pin_sync #(.WIDTH(3 + WATCH_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({serial_in.sclk, serial_in.din, ~serial_in.cs_n, watched_pins}),
    .sync_out({link_sync, pins_sync})
  );

  wire sclk_s = link_sync[2];
  wire din_s = link_sync[1];
  wire cs_n_s = ~link_sync[0];
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  wire cs_rise = cs_n_s & ~cs_prev_reg;
  wire selected = ~cs_n_s;

  command_t cmd;
  assign cmd = command_t'(shift_reg);
  wire do_read = cs_rise & cmd.is_read;
  wire do_write = cs_rise & ~cmd.is_read;
  wire cfg_write = do_write & (cmd.addr == ADDR_CONFIG);
  wire mask_access = cs_rise & (cmd.addr == ADDR_MASK);
  wire arm_write = cfg_write & cmd.data[CFG_DETECT_BIT];
  wire [WATCH_W-1:0] diff = (pins_sync ^ snap_reg) & mask_reg;
  wire change_seen = armed_reg & (|diff);

  logic [7:0] read_data;
  always_comb begin
    unique case (cmd.addr)
      ADDR_CONFIG: read_data = config_reg;
      ADDR_MASK: read_data = {1'b0, mask_reg};
      default: read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg <= cs_n_s;
    end
  end

  // shift on rise only while selected
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= SHIFT_RESET;
    end else if (do_read) begin
      // low byte replaced by register data
      shift_reg <= {shift_reg[WORD_W-1:DATA_HI+1], read_data};
    end else if (selected && sclk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], din_s};
    end
  end

  // output changes on falling edge, always driven
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
    end else if (selected && sclk_fall) begin
      serial_out <= shift_reg[WORD_W-1];
    end
  end

  // execute latched word; reset means shutdown
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_reg <= CONFIG_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      if (cfg_write) begin
        config_reg <= cmd.data;
      end
      if (do_write && cmd.addr == ADDR_MASK) begin
        mask_reg <= cmd.data[WATCH_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_reg <= '0;
      armed_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else begin
      if (arm_write) begin
        snap_reg <= pins_sync;
        armed_reg <= 1'b1;
        alert_reg <= 1'b0;
      end else begin
        if (cfg_write || change_seen) begin
          armed_reg <= 1'b0;
        end
        if (change_seen) begin
          alert_reg <= 1'b1;
        end else if (mask_access) begin
          alert_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_pin <= 1'b0;
      shutdown <= 1'b1;
      detect_armed <= 1'b0;
      config_value <= CONFIG_RESET;
      watch_mask <= MASK_RESET;
    end else begin
      alert_pin <= alert_reg;
      shutdown <= ~config_reg[CFG_RUN_BIT];
      detect_armed <= armed_reg;
      config_value <= config_reg;
      watch_mask <= mask_reg;
    end
  end

  a_alert_latches: assert property (@(posedge clk) disable iff (sys_rst)
    change_seen && !arm_write |=> alert_reg)
    else $error("alert not latched on change");
  a_alert_holds: assert property (@(posedge clk) disable iff (sys_rst)
    alert_reg && !mask_access && !arm_write |=> alert_reg)
    else $error("alert dropped without mask access");
  a_arm_snapshot: assert property (@(posedge clk) disable iff (sys_rst)
    arm_write |=> armed_reg && snap_reg == $past(pins_sync) && !alert_reg)
    else $error("arm write did not snapshot");
  a_oneshot_disarm: assert property (@(posedge clk) disable iff (sys_rst)
    change_seen && !arm_write |=> !armed_reg)
    else $error("detection stayed armed after change");
  a_idle_shift: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n_s && !do_read |=> shift_reg == $past(shift_reg))
    else $error("shift changed while deselected");
  a_shift_in: assert property (@(posedge clk) disable iff (sys_rst)
    selected && sclk_rise |=> shift_reg[0] == $past(din_s))
    else $error("bit not shifted in");
  a_read_load: assert property (@(posedge clk) disable iff (sys_rst)
    do_read |=> shift_reg[7:0] == $past(read_data))
    else $error("read data not loaded");
  a_alert_pin: assert property (@(posedge clk) disable iff (sys_rst)
    alert_reg |=> alert_pin)
    else $error("alert pin not following latch");
  a_mask_write: assert property (@(posedge clk) disable iff (sys_rst)
    do_write && cmd.addr == ADDR_MASK |=> mask_reg == WATCH_W'($past(shift_reg)))
    else $error("mask write not executed");
endmodule : serial_cmd_port_change_detect
`default_nettype wire

/* tb_top.sv */
/*
  Self-checking bench for the serial command port with change detect.
  Assumes host_model drives the serial pins at a 160 ns link period.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import serial_cmd_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [7:0] cfg;
    logic [6:0] msk;
  } row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] watched_pins = 7'h00;
  serial_in_t serial_in;
  logic serial_out, alert_pin, shutdown, detect_armed;
  logic [7:0] config_value;
  logic [6:0] watch_mask;
  logic [15:0] got, prev;
  int error_cnt = 0;
  int comparisons = 0;
  wire logic [17:0] st = {alert_pin, detect_armed, shutdown, config_value, watch_mask};
  row_t rows [6] = '{'{16'h0401, 8'h01, 7'h00}, '{16'h06ff, 8'h01, 7'h7f},
    '{16'h0555, 8'h01, 7'h7f}, '{16'h0000, 8'h01, 7'h7f},
    '{16'h0400, 8'h00, 7'h7f}, '{16'h0600, 8'h00, 7'h00}};
  always #10 clk = ~clk;
  host_model host (.clk(clk), .serial_in(serial_in), .serial_out(serial_out));
  serial_cmd_port_change_detect DUT (.clk(clk), .sys_rst(sys_rst), .serial_in(serial_in),
    .serial_out(serial_out), .watched_pins(watched_pins), .alert_pin(alert_pin),
    .shutdown(shutdown), .detect_armed(detect_armed), .config_value(config_value),
    .watch_mask(watch_mask));
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic s(input logic [15:0] w);
    host.xfer(w, 8'h00, 1'b0, got);
  endtask : s
  // Pins settle through the synchroniser before checks
  task automatic pins(input logic [6:0] v);
    watched_pins = v;
    #200;
  endtask : pins
  initial begin
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    chk(st, {3'b001, 15'h0000});
    $display("reset test done");
    repeat (4) @(posedge clk);
    prev = '0;
    foreach (rows[i]) begin
      s(rows[i].w);
      chk(got, {prev[14:0], rows[i].w[15]});
      chk(st, {2'b00, ~rows[i].cfg[0], rows[i].cfg, rows[i].msk});
      prev = rows[i].w;
    end
    $display("row tests done");
    host.noise();
    s(16'h0000);
    chk(got, {prev[14:0], 1'b0});
    host.xfer(16'h0603, 8'hff, 1'b1, got);
    chk(st, {3'b001, 8'h00, 7'h03});
    s(16'h0f40);
    chk(st, {3'b001, 8'h00, 7'h03});
    s(16'h0481);
    chk(st, {3'b010, 8'h81, 7'h03});
    pins(7'h20);
    chk(st, {3'b010, 8'h81, 7'h03});
    watched_pins = 7'h21;
    #60 pins(7'h20);
    chk(st, {3'b100, 8'h81, 7'h03});
    s(16'h8600);
    chk(st, {3'b000, 8'h81, 7'h03});
    s(16'h0000);
    chk(got, {7'h06, 8'h03, 1'b0});
    pins(7'h23);
    chk(st, {3'b000, 8'h81, 7'h03});
    s(16'h0481);
    chk(st, {3'b010, 8'h81, 7'h03});
    pins(7'h22);
    chk(st, {3'b100, 8'h81, 7'h03});
    s(16'h0401);
    chk(st, {3'b100, 8'h01, 7'h03});
    s(16'h0603);
    chk(st, {3'b000, 8'h01, 7'h03});
    $display("detect tests done");
    @(posedge clk) #2 sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    chk(st, {3'b001, 15'h0000});
    s(16'h0481);
    chk(got, 16'h0000);
    chk(st, {3'b010, 8'h81, 7'h00});
    $display("reset again done");
    print_verdict();
  end
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
